// ---- tb_top.sv ----
// Self-checking bench for the endpoint FIFO access block.
// Assumes uefa_core and uefa_host_model are compiled after uefa_pkg.
`timescale 1ns/1ps
module tb_top import uefa_pkg::*; ;
	typedef struct packed {logic [2:0] ep; logic [6:0] n; logic iso; logic en;} uefa_row_type;
	logic CLK, RST_N, SFR_WR, SFR_RD, SIE_WR, SIE_SETUP, SIE_RD;
	logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, SIE_WDATA, SIE_RDATA;
	logic [EP_W-1:0] ENDPOINT_SELECT, SIE_DATA_EP;
	logic [NUM_EP-1:0] EP_ISO, EP_CONTROL, EP_INT_ENABLE, ARM_IN_PACKET;
	logic [NUM_EP-1:0] CLR_BANK0_OUT_RECEIVED, CLR_IN_TRANSFER_DONE, CLR_SETUP_RECEIVED;
	logic [NUM_EP-1:0] BANK0_OUT_RECEIVED, IN_TRANSFER_DONE, SETUP_RECEIVED;
	logic [NUM_EP-1:0] IN_PACKET_ARMED, OUT_NAK, ENDPOINT_INT;
	uefa_sie_event_type SIE_EVENT;
	int n_fail, n_checks, cycles;
	uefa_row_type r;
	uefa_row_type rows [4] = '{'{3'd1, 7'd1, 1'b0, 1'b1}, '{3'd2, 7'd64, 1'b1, 1'b0},
		'{3'd5, 7'd3, 1'b0, 1'b1}, '{3'd0, 7'd17, 1'b0, 1'b1}};
	uefa_core u_uefa_core (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
		.SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
		.ENDPOINT_SELECT(ENDPOINT_SELECT), .EP_ISO(EP_ISO), .EP_CONTROL(EP_CONTROL),
		.EP_INT_ENABLE(EP_INT_ENABLE), .CLR_BANK0_OUT_RECEIVED(CLR_BANK0_OUT_RECEIVED),
		.CLR_IN_TRANSFER_DONE(CLR_IN_TRANSFER_DONE), .CLR_SETUP_RECEIVED(CLR_SETUP_RECEIVED),
		.ARM_IN_PACKET(ARM_IN_PACKET), .SIE_DATA_EP(SIE_DATA_EP), .SIE_WR(SIE_WR),
		.SIE_SETUP(SIE_SETUP), .SIE_WDATA(SIE_WDATA), .SIE_RD(SIE_RD), .SIE_RDATA(SIE_RDATA),
		.SIE_EVENT(SIE_EVENT), .BANK0_OUT_RECEIVED(BANK0_OUT_RECEIVED),
		.IN_TRANSFER_DONE(IN_TRANSFER_DONE), .SETUP_RECEIVED(SETUP_RECEIVED),
		.IN_PACKET_ARMED(IN_PACKET_ARMED), .OUT_NAK(OUT_NAK), .ENDPOINT_INT(ENDPOINT_INT));
	uefa_host_model u_uefa_host_model (.clk(CLK), .data_ep(SIE_DATA_EP), .wr(SIE_WR),
		.setup(SIE_SETUP), .wdata(SIE_WDATA), .rd(SIE_RD), .rdata(SIE_RDATA), .nak(OUT_NAK),
		.ev(SIE_EVENT));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Strobes drop for one edge between accesses, so no access is ever merged with the next.
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		SFR_WR <= wr;
		SFR_RD <= !wr;
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		@(posedge CLK);
		SFR_WR <= 1'b0;
		SFR_RD <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr(1'b0, a, 8'h00);
		chk(SFR_RDATA, exp);
	endtask
	task automatic rd_pkt(input logic [2:0] ep, input int n);
		for (int i = 0; i < n; i++) rd(ADDR_FIFO_DATA, {ep, 5'h00} + 8'(i));
	endtask
	// One-cycle firmware pulse on {arm, clear done, clear setup, clear bank 0}.
	task automatic fw(input logic [23:0] v);
		@(posedge CLK);
		{ARM_IN_PACKET, CLR_IN_TRANSFER_DONE, CLR_SETUP_RECEIVED, CLR_BANK0_OUT_RECEIVED} <= v;
		@(posedge CLK);
		{ARM_IN_PACKET, CLR_IN_TRANSFER_DONE, CLR_SETUP_RECEIVED, CLR_BANK0_OUT_RECEIVED} <= '0;
		#1;
	endtask
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{RST_N, SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA, ENDPOINT_SELECT, EP_ISO} = '0;
		{EP_INT_ENABLE, ARM_IN_PACKET, CLR_IN_TRANSFER_DONE} = '0;
		{CLR_SETUP_RECEIVED, CLR_BANK0_OUT_RECEIVED} = '0;
		EP_CONTROL = 6'h01;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		rd(ADDR_BYTE_COUNT_LOW, BYTE_COUNT_RESET);
		rd(ADDR_BYTE_COUNT_HIGH, BYTE_COUNT_RESET);
		foreach (rows[k]) begin
			r = rows[k];
			@(posedge CLK);
			ENDPOINT_SELECT <= r.ep;
			EP_ISO <= 6'(r.iso) << r.ep;
			EP_INT_ENABLE <= 6'(r.en) << r.ep;
			u_uefa_host_model.send(r.ep, 32'(r.n), 1'b0);
			chk({BANK0_OUT_RECEIVED[r.ep], OUT_NAK[r.ep], ENDPOINT_INT[r.ep]}, {1'b1, !r.iso, r.en});
			rd(ADDR_BYTE_COUNT_LOW, 8'(r.n));
			rd(ADDR_BYTE_COUNT_HIGH, 8'h00);
			rd_pkt(r.ep, 32'(r.n));
			fw(24'(1) << r.ep);
			chk(8'(BANK0_OUT_RECEIVED[r.ep]), 8'h00);
		end
		// A second packet while bank 0 is full must be refused without touching the count.
		@(posedge CLK);
		ENDPOINT_SELECT <= 3'd3;
		EP_ISO <= '0;
		u_uefa_host_model.send(3'd3, 2, 1'b0);
		chk(8'(OUT_NAK[3]), 8'h01);
		u_uefa_host_model.send(3'd3, 4, 1'b0);
		rd(ADDR_BYTE_COUNT_LOW, 8'h02);
		rd_pkt(3'd3, 2);
		fw(24'h000008);
		// Refused bytes must not have been counted into the next packet.
		u_uefa_host_model.send(3'd3, 1, 1'b0);
		rd(ADDR_BYTE_COUNT_LOW, 8'h01);
		// An early SETUP replaces unread data on the control endpoint.
		@(posedge CLK);
		ENDPOINT_SELECT <= 3'd0;
		EP_INT_ENABLE <= 6'h11;
		u_uefa_host_model.send(3'd0, 2, 1'b0);
		u_uefa_host_model.send(3'd0, 8, 1'b1);
		chk({SETUP_RECEIVED[0], BANK0_OUT_RECEIVED[0], ENDPOINT_INT[0]}, 8'h07);
		rd(ADDR_BYTE_COUNT_LOW, 8'h08);
		rd_pkt(3'd0, 8);
		fw(24'h000041);
		chk(8'(SETUP_RECEIVED[0]), 8'h00);
		// A SETUP end on a non-control endpoint must not raise the SETUP flag.
		u_uefa_host_model.send(3'd5, 1, 1'b1);
		chk(8'(SETUP_RECEIVED[5]), 8'h00);
		// IN transfer on endpoint 4: fill, arm, let the host pop and acknowledge.
		@(posedge CLK);
		ENDPOINT_SELECT <= 3'd4;
		for (int i = 0; i < 3; i++) sfr(1'b1, ADDR_FIFO_DATA, 8'hA0 + 8'(i));
		fw(24'h400000);
		chk(8'(IN_PACKET_ARMED[4]), 8'h01);
		u_uefa_host_model.fetch(3'd4, 3);
		for (int i = 0; i < 3; i++) chk(u_uefa_host_model.got[i], 8'hA0 + 8'(i));
		u_uefa_host_model.finish_in(3'd4);
		chk({IN_PACKET_ARMED[4], IN_TRANSFER_DONE[4], ENDPOINT_INT[4]}, 8'h03);
		fw(24'h010000);
		chk({IN_TRANSFER_DONE[4], ENDPOINT_INT[4]}, 8'h00);
		rd(8'h00, UNMAPPED_READ);
		// A long packet reaches the upper count bits; a reset in mid-run must clear them.
		@(posedge CLK);
		ENDPOINT_SELECT <= 3'd1;
		u_uefa_host_model.send(3'd1, 300, 1'b0);
		rd(ADDR_BYTE_COUNT_LOW, 8'h2C);
		rd(ADDR_BYTE_COUNT_HIGH, 8'h01);
		@(posedge CLK);
		RST_N <= 1'b0;
		@(posedge CLK);
		RST_N <= 1'b1;
		rd(ADDR_BYTE_COUNT_LOW, BYTE_COUNT_RESET);
		rd(ADDR_BYTE_COUNT_HIGH, BYTE_COUNT_RESET);
		give_verdict();
	end
endmodule

// ---- uefa_core.sv ----
// Top of the USB endpoint FIFO access path: data port, byte counts and transfer flags.
// Assumes the endpoint index comes from an outside register and the serial engine
// honours OUT_NAK and pulses its events for one cycle.
`timescale 1ns/1ps
module uefa_core import uefa_pkg::*; (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic [EP_W-1:0] ENDPOINT_SELECT,
	input wire logic [NUM_EP-1:0] EP_ISO,
	input wire logic [NUM_EP-1:0] EP_CONTROL,
	input wire logic [NUM_EP-1:0] EP_INT_ENABLE,
	input wire logic [NUM_EP-1:0] CLR_BANK0_OUT_RECEIVED,
	input wire logic [NUM_EP-1:0] CLR_IN_TRANSFER_DONE,
	input wire logic [NUM_EP-1:0] CLR_SETUP_RECEIVED,
	input wire logic [NUM_EP-1:0] ARM_IN_PACKET,
	input wire logic [EP_W-1:0] SIE_DATA_EP,
	input wire logic SIE_WR,
	input wire logic SIE_SETUP,
	input wire logic [7:0] SIE_WDATA,
	input wire logic SIE_RD,
	output logic [7:0] SIE_RDATA,
	input wire uefa_sie_event_type SIE_EVENT,
	output logic [NUM_EP-1:0] BANK0_OUT_RECEIVED,
	output logic [NUM_EP-1:0] IN_TRANSFER_DONE,
	output logic [NUM_EP-1:0] SETUP_RECEIVED,
	output logic [NUM_EP-1:0] IN_PACKET_ARMED,
	output logic [NUM_EP-1:0] OUT_NAK,
	output logic [NUM_EP-1:0] ENDPOINT_INT
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] byte_count [NUM_EP];
	logic [CNT_W-1:0] next_byte_count [NUM_EP];
	logic [CNT_W-1:0] pkt_cnt [NUM_EP];
	logic [CNT_W-1:0] next_pkt_cnt [NUM_EP];
	logic [NUM_EP-1:0] next_bank0, next_in_done, next_setup, next_armed, next_int, next_nak;
	logic [NUM_EP-1:0] in_done_set, flush;
	logic [7:0] next_sfr_rdata, fifo_cpu_rdata, fifo_sie_rdata;
	logic [CNT_W-1:0] sel_count;
	logic sie_acc, cpu_we, cpu_re, sel_ok;

	function automatic logic is_ep(input logic [EP_W-1:0] ep, input int e);
		return int'(ep) == e;
	endfunction

	// ----------------------------------------------------------------
	// FIFO access
	// ----------------------------------------------------------------
	assign sel_ok = int'(ENDPOINT_SELECT) < NUM_EP;
	assign sel_count = sel_ok ? byte_count[ENDPOINT_SELECT] : '0;
	// Engine OUT data is taken unless NAKed; a control SETUP always gets through.
	assign sie_acc = SIE_WR && int'(SIE_DATA_EP) < NUM_EP
		&& (!OUT_NAK[SIE_DATA_EP] || (SIE_SETUP && EP_CONTROL[SIE_DATA_EP]));
	// Processor writes are held off while an IN packet is armed and waiting.
	assign cpu_we = SFR_WR && SFR_ADDR == ADDR_FIFO_DATA && sel_ok
		&& !IN_PACKET_ARMED[ENDPOINT_SELECT];
	assign cpu_re = SFR_RD && SFR_ADDR == ADDR_FIFO_DATA && sel_ok;

	always_comb begin
		for (int e = 0; e < NUM_EP; e++) begin
			flush[e] = CLR_BANK0_OUT_RECEIVED[e] || in_done_set[e];
			if (sie_acc && is_ep(SIE_DATA_EP, e) && SIE_SETUP && pkt_cnt[e] == '0) begin
				flush[e] = 1'b1;
			end
		end
	end

	uefa_ep_fifo #(
		.NEP(NUM_EP),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.cpu_we(cpu_we),
		.cpu_re(cpu_re),
		.cpu_ep(ENDPOINT_SELECT),
		.cpu_wdata(SFR_WDATA),
		.cpu_rdata(fifo_cpu_rdata),
		.sie_we(sie_acc),
		.sie_re(SIE_RD),
		.sie_ep(SIE_DATA_EP),
		.sie_wdata(SIE_WDATA),
		.sie_rdata(fifo_sie_rdata),
		.flush(flush)
	);

	// ----------------------------------------------------------------
	// Byte counts
	// ----------------------------------------------------------------
	always_comb begin
		for (int e = 0; e < NUM_EP; e++) begin
			next_pkt_cnt[e] = pkt_cnt[e];
			next_byte_count[e] = byte_count[e];
			if (sie_acc && is_ep(SIE_DATA_EP, e)) begin
				next_pkt_cnt[e] = pkt_cnt[e] + 1'b1;
			end
			if ((SIE_EVENT.out_end || SIE_EVENT.setup_end) && is_ep(SIE_EVENT.ep, e)) begin
				next_byte_count[e] = pkt_cnt[e];
				next_pkt_cnt[e] = '0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int e = 0; e < NUM_EP; e++) begin
				byte_count[e] <= '0;
				pkt_cnt[e] <= '0;
			end
		end else begin
			byte_count <= next_byte_count;
			pkt_cnt <= next_pkt_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Register read data
	// ----------------------------------------------------------------
	always_comb begin
		next_sfr_rdata = SFR_RDATA;
		if (SFR_RD) begin
			case (SFR_ADDR)
				ADDR_FIFO_DATA: next_sfr_rdata = sel_ok ? fifo_cpu_rdata : UNMAPPED_READ;
				ADDR_BYTE_COUNT_LOW: next_sfr_rdata = sel_count[7:0];
				ADDR_BYTE_COUNT_HIGH: begin
					next_sfr_rdata = BYTE_COUNT_RESET;
					next_sfr_rdata[CNT_HIGH_LSB +: CNT_HIGH_W] = sel_count[CNT_W-1:8];
				end
				default: next_sfr_rdata = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SFR_RDATA <= UNMAPPED_READ;
			SIE_RDATA <= UNMAPPED_READ;
		end else begin
			SFR_RDATA <= next_sfr_rdata;
			SIE_RDATA <= SIE_RD ? fifo_sie_rdata : SIE_RDATA;
		end
	end

	// ----------------------------------------------------------------
	// Transfer flags, NAK and interrupt
	// ----------------------------------------------------------------
	// A hardware set always beats a firmware clear in the same cycle, so no event is lost.
	always_comb begin
		for (int e = 0; e < NUM_EP; e++) begin
			in_done_set[e] = is_ep(SIE_EVENT.ep, e) && IN_PACKET_ARMED[e]
				&& (EP_ISO[e] ? SIE_EVENT.in_sent : SIE_EVENT.in_ack);
			next_bank0[e] = (BANK0_OUT_RECEIVED[e] && !CLR_BANK0_OUT_RECEIVED[e])
				|| (SIE_EVENT.out_end && is_ep(SIE_EVENT.ep, e));
			next_setup[e] = (SETUP_RECEIVED[e] && !CLR_SETUP_RECEIVED[e])
				|| (SIE_EVENT.setup_end && is_ep(SIE_EVENT.ep, e) && EP_CONTROL[e]);
			next_in_done[e] = (IN_TRANSFER_DONE[e] && !CLR_IN_TRANSFER_DONE[e])
				|| in_done_set[e];
			next_armed[e] = ARM_IN_PACKET[e] || (IN_PACKET_ARMED[e] && !in_done_set[e]);
		end
		next_nak = next_bank0 & ~EP_ISO;
		next_int = EP_INT_ENABLE & (next_bank0 | next_setup | next_in_done);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BANK0_OUT_RECEIVED <= '0;
			IN_TRANSFER_DONE <= '0;
			SETUP_RECEIVED <= '0;
			IN_PACKET_ARMED <= '0;
			OUT_NAK <= '0;
			ENDPOINT_INT <= '0;
		end else begin
			BANK0_OUT_RECEIVED <= next_bank0;
			IN_TRANSFER_DONE <= next_in_done;
			SETUP_RECEIVED <= next_setup;
			IN_PACKET_ARMED <= next_armed;
			OUT_NAK <= next_nak;
			ENDPOINT_INT <= next_int;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_bank0_on_end: assert property (SIE_EVENT.out_end && int'(SIE_EVENT.ep) < NUM_EP
		|=> BANK0_OUT_RECEIVED[$past(SIE_EVENT.ep)])
		else $error("Bank 0 flag not set after OUT packet end.");
	a_nak_tracks_flag: assert property (##1 OUT_NAK == (BANK0_OUT_RECEIVED & ~$past(EP_ISO)))
		else $error("NAK does not follow bank 0 flag.");
	a_setup_passes: assert property (SIE_WR && SIE_SETUP && int'(SIE_DATA_EP) < NUM_EP
		&& EP_CONTROL[SIE_DATA_EP] |-> sie_acc)
		else $error("Control SETUP data was refused.");
	a_in_done_sets: assert property (SIE_EVENT.in_ack && int'(SIE_EVENT.ep) < NUM_EP
		&& IN_PACKET_ARMED[SIE_EVENT.ep] && !EP_ISO[SIE_EVENT.ep]
		|=> IN_TRANSFER_DONE[$past(SIE_EVENT.ep)])
		else $error("IN done flag not set after acknowledge.");
	a_armed_clears: assert property ((in_done_set & ~ARM_IN_PACKET) != '0
		|=> (IN_PACKET_ARMED & $past(in_done_set & ~ARM_IN_PACKET)) == '0)
		else $error("Packet ready stayed set after completion.");
	a_count_latch: assert property (SIE_EVENT.out_end && int'(SIE_EVENT.ep) < NUM_EP
		&& !(sie_acc && SIE_DATA_EP == SIE_EVENT.ep)
		|=> byte_count[$past(SIE_EVENT.ep)] == $past(pkt_cnt[SIE_EVENT.ep]))
		else $error("Byte count not latched at packet end.");
	a_low_read: assert property (SFR_RD && SFR_ADDR == ADDR_BYTE_COUNT_LOW
		|=> SFR_RDATA == $past(sel_count[7:0]))
		else $error("Low byte count read wrong copy.");
	a_high_zero: assert property (SFR_RD && SFR_ADDR == ADDR_BYTE_COUNT_HIGH
		|=> SFR_RDATA[7:CNT_HIGH_W] == '0 && SFR_RDATA[CNT_HIGH_W-1:0] == $past(sel_count[10:8]))
		else $error("High byte count read wrong.");
	a_data_read: assert property (SFR_RD && SFR_ADDR == ADDR_FIFO_DATA && sel_ok
		|=> SFR_RDATA == $past(fifo_cpu_rdata))
		else $error("Data port returned wrong byte.");
	a_setup_flag: assert property (SIE_EVENT.setup_end && int'(SIE_EVENT.ep) < NUM_EP
		&& EP_CONTROL[SIE_EVENT.ep] |=> SETUP_RECEIVED[$past(SIE_EVENT.ep)])
		else $error("SETUP flag not set.");
endmodule

// ---- uefa_ep_fifo.sv ----
// Per-endpoint byte FIFO with a processor port and a serial engine port.
// Assumes at most one write and one read per port per cycle; flush rewinds an endpoint.
`timescale 1ns/1ps
module uefa_ep_fifo import uefa_pkg::*; #(
	parameter int NEP = NUM_EP,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_we,
	input wire logic cpu_re,
	input wire logic [EP_W-1:0] cpu_ep,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	input wire logic sie_we,
	input wire logic sie_re,
	input wire logic [EP_W-1:0] sie_ep,
	input wire logic [7:0] sie_wdata,
	output logic [7:0] sie_rdata,
	input wire logic [NEP-1:0] flush
);
	localparam int PW = $clog2(DEPTH);
	logic [7:0] mem [NEP*DEPTH];
	logic [PW-1:0] wptr [NEP];
	logic [PW-1:0] rptr [NEP];
	logic [PW-1:0] next_wptr [NEP];
	logic [PW-1:0] next_rptr [NEP];
	logic cpu_wr_ok;

	function automatic int unsigned slot(input logic [EP_W-1:0] ep, input logic [PW-1:0] p);
		return int'(ep) * DEPTH + int'(p);
	endfunction

	function automatic logic ep_ok(input logic [EP_W-1:0] ep);
		return int'(ep) < NEP;
	endfunction

	function automatic logic [PW-1:0] base(input logic f, input logic [PW-1:0] p);
		return f ? '0 : p;
	endfunction

	// The engine wins a same-endpoint write collision; the processor byte is dropped.
	assign cpu_wr_ok = cpu_we && ep_ok(cpu_ep) && !(sie_we && sie_ep == cpu_ep);

	always_comb begin
		for (int e = 0; e < NEP; e++) begin
			next_wptr[e] = base(flush[e], wptr[e]);
			next_rptr[e] = base(flush[e], rptr[e]);
			if ((sie_we && int'(sie_ep) == e) || (cpu_wr_ok && int'(cpu_ep) == e)) begin
				next_wptr[e] = next_wptr[e] + 1'b1;
			end
			if ((sie_re && int'(sie_ep) == e) || (cpu_re && int'(cpu_ep) == e)) begin
				next_rptr[e] = next_rptr[e] + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int e = 0; e < NEP; e++) begin
				wptr[e] <= '0;
				rptr[e] <= '0;
			end
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end

	// Storage has no reset, so the data port reads undefined bytes until filled.
	always_ff @(posedge clk) begin
		if (sie_we && ep_ok(sie_ep)) begin
			mem[slot(sie_ep, base(flush[sie_ep], wptr[sie_ep]))] <= sie_wdata;
		end
		if (cpu_wr_ok) begin
			mem[slot(cpu_ep, base(flush[cpu_ep], wptr[cpu_ep]))] <= cpu_wdata;
		end
	end

	assign cpu_rdata = ep_ok(cpu_ep) ? mem[slot(cpu_ep, rptr[cpu_ep])] : UNMAPPED_READ;
	assign sie_rdata = ep_ok(sie_ep) ? mem[slot(sie_ep, rptr[sie_ep])] : UNMAPPED_READ;
endmodule

// ---- uefa_host_model.sv ----
// Model of the USB host as seen through the serial engine side of the block.
// Assumes the bench calls its tasks one at a time; signals change only at rising edges.
`timescale 1ns/1ps
module uefa_host_model import uefa_pkg::*; (
	input wire logic clk,
	output logic [EP_W-1:0] data_ep,
	output logic wr,
	output logic setup,
	output logic [7:0] wdata,
	output logic rd,
	input wire logic [7:0] rdata,
	input wire logic [NUM_EP-1:0] nak,
	output uefa_sie_event_type ev
);
	logic [7:0] got [0:63];
	initial begin
		data_ep = '0;
		wr = 1'b0;
		setup = 1'b0;
		wdata = 8'h00;
		rd = 1'b0;
		ev = '0;
	end
	// ------------------------------------------------------------
	// Transfers
	// ------------------------------------------------------------
	// Bytes go out whether or not the engine NAKs, as a real host would retry blindly.
	// A NAKed OUT packet is never stored, so the engine sends no end event for it.
	task automatic send(input logic [EP_W-1:0] ep, input int n, input logic is_setup);
		logic refused;
		refused = nak[ep] && !is_setup;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			data_ep <= ep;
			setup <= is_setup;
			wr <= 1'b1;
			wdata <= {ep, 5'h00} + 8'(i);
		end
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~wdata;
		if (refused) begin
			ev <= '0;
		end else begin
			ev <= '{ep, !is_setup, is_setup, 1'b0, 1'b0};
		end
		@(posedge clk);
		ev <= '0;
		#1;
	endtask
	task automatic fetch(input logic [EP_W-1:0] ep, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			data_ep <= ep;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			got[i] = rdata;
		end
	endtask
	// The host acknowledges every IN packet it receives.
	task automatic finish_in(input logic [EP_W-1:0] ep);
		@(posedge clk);
		ev <= '{ep, 1'b0, 1'b0, 1'b1, 1'b1};
		@(posedge clk);
		ev <= '0;
		#1;
	endtask
endmodule

// ---- uefa_pkg.sv ----
// Shared constants and types for the USB endpoint FIFO access block.
// Assumes an 8-bit register port and a serial engine that reports packet events.
package uefa_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_EP = 6;
	localparam int EP_W = 3;
	localparam int FIFO_DEPTH = 64;
	localparam int CNT_W = 11;
	localparam int CNT_HIGH_W = CNT_W - 8;
	localparam int CNT_HIGH_LSB = 0;
	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FIFO_DATA = 8'hCF;
	localparam logic [7:0] ADDR_BYTE_COUNT_LOW = 8'hE2;
	localparam logic [7:0] ADDR_BYTE_COUNT_HIGH = 8'hE3;
	localparam logic [7:0] BYTE_COUNT_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// ----------------------------------------------------------------
	// Serial engine events, one-cycle pulses for the endpoint in ep
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [EP_W-1:0] ep;
		logic out_end;
		logic setup_end;
		logic in_sent;
		logic in_ack;
	} uefa_sie_event_type;
endpackage
